// *** bmwb_defines.vh ***
// Constants for the base mode word decoder and burst engine.
// Assumes a single 10 MHz clock and includes through a bare name.
`ifndef BMWB_DEFINES_VH
`define BMWB_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Clock
`define BMWB_CLK_MHZ 10

////////////////////////////////////////////////////////////////////////////////
// Base mode word fields
`define BMWB_WORD_W 19
`define BMWB_WORD_RESET 19'h00000
`define BMWB_BL_LSB 0
`define BMWB_BL_MSB 1
`define BMWB_CL_LOW_BIT 2
`define BMWB_BT_BIT 3
`define BMWB_CL_LSB 4
`define BMWB_CL_MSB 6
`define BMWB_DLLRST_BIT 8
`define BMWB_WR_LSB 9
`define BMWB_WR_MSB 11
`define BMWB_PPD_BIT 12

// Length field codes
`define BMWB_BL_FIXED8 2'h0
`define BMWB_BL_PERCMD 2'h1
`define BMWB_BL_CHOP4 2'h2

////////////////////////////////////////////////////////////////////////////////
// Counts and timing
`define BMWB_LOCK_CYCLES 10'h200
`define BMWB_CL_MIN 4'h5
`define BMWB_WR_MIN 4'h5
`define BMWB_PIPE_DEPTH 12
`define BMWB_FAST_EXIT_NS 30
`define BMWB_SLOW_EXIT_NS 300
// Least times round up to whole cycles
`define BMWB_FAST_EXIT_CYC ((`BMWB_FAST_EXIT_NS * `BMWB_CLK_MHZ + 999) / 1000)
`define BMWB_SLOW_EXIT_CYC ((`BMWB_SLOW_EXIT_NS * `BMWB_CLK_MHZ + 999) / 1000)

`endif

// *** bmwb_beat_order.v ***
// Column order of one beat within a burst.
// Pure logic; the caller registers the result.
`timescale 1ns/1ps

module bmwb_beat_order (
  input wire [2:0] i_start_col,
  input wire [2:0] i_beat,
  input wire i_interleave,
  input wire i_chop,
  input wire i_write,
  output reg [2:0] o_col
);
  reg [1:0] low_sum;

  always @* begin
    low_sum = i_start_col[1:0] + i_beat[1:0];
    if (i_write) begin
      // Writes ignore the low start bits
      if (i_chop) begin
        o_col = {i_start_col[2], i_beat[1:0]};
      end else begin
        o_col = i_beat;
      end
    end else if (i_interleave) begin
      o_col = i_start_col ^ i_beat;
    end else begin
      // Wrap inside the nibble, then move to the other one
      o_col = {i_start_col[2] ^ i_beat[2], low_sum};
    end
  end
endmodule

// *** bmwb_mode_burst.v ***
// Base mode word store, decode and burst beat engine.
// Assumes commands arrive synchronous to i_mclk from the controller's logic.
`timescale 1ns/1ps
`include "bmwb_defines.vh"

module bmwb_mode_burst (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_mode_set_command,
  input wire [18:0] i_mode_word,
  input wire i_rd_cmd,
  input wire i_wr_cmd,
  input wire [2:0] i_col_addr,
  input wire i_column_addr_bit_twelve,
  input wire i_idle_bank_sleep,
  output reg [18:0] o_base_mode_word,
  output reg [2:0] o_beat_col,
  output reg o_rd_beat_valid,
  output reg o_dq_oe,
  output reg o_wr_beat_valid,
  output reg o_burst_eight,
  output reg o_dll_reset,
  output reg o_loop_locked,
  output reg [3:0] o_read_column_latency,
  output reg [3:0] o_write_recovery,
  output reg o_dll_stopped,
  output reg o_sleep_exit_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // Mode word store and decode
  reg [18:0] mode_r;
  reg [3:0] cl_nxt;
  reg [3:0] wr_nxt;
  reg chop_nxt;
  wire [1:0] bl_code;
  wire [2:0] cl_code;
  wire [2:0] wr_code;

  assign bl_code = mode_r[`BMWB_BL_MSB:`BMWB_BL_LSB];
  assign cl_code = mode_r[`BMWB_CL_MSB:`BMWB_CL_LSB];
  assign wr_code = mode_r[`BMWB_WR_MSB:`BMWB_WR_LSB];

  // Reserved bits are stored as written; clearing them is the controller's job
  // A new word with bit 8 set wins over the self-clear in the same cycle
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_r <= `BMWB_WORD_RESET;
    end else if (i_mode_set_command) begin
      mode_r <= i_mode_word;
    end else if (mode_r[`BMWB_DLLRST_BIT]) begin
      mode_r[`BMWB_DLLRST_BIT] <= 1'b0;
    end
  end

  // Latency: bit 2 extends the code past 11; unused codes fall back to 5
  // Falling back keeps the pipe tap inside its twelve stages
  always @* begin
    cl_nxt = `BMWB_CL_MIN;
    if (!mode_r[`BMWB_CL_LOW_BIT]) begin
      if (cl_code != 3'h0) begin
        cl_nxt = 4'h4 + {1'b0, cl_code};
      end
    end else begin
      if (cl_code == 3'h0) begin
        cl_nxt = 4'hC;
      end else if (cl_code == 3'h1) begin
        cl_nxt = 4'hD;
      end
    end
  end

  // Write recovery codes 1..7 give 5,6,7,8,10,12,14
  // Code 0 is unused and reads as the shortest recovery
  always @* begin
    case (wr_code)
      3'h1: wr_nxt = 4'h5;
      3'h2: wr_nxt = 4'h6;
      3'h3: wr_nxt = 4'h7;
      3'h4: wr_nxt = 4'h8;
      3'h5: wr_nxt = 4'hA;
      3'h6: wr_nxt = 4'hC;
      3'h7: wr_nxt = 4'hE;
      default: wr_nxt = `BMWB_WR_MIN;
    endcase
  end

  // One length decision serves reads and writes; code 11 acts as eight
  always @* begin
    case (bl_code)
      `BMWB_BL_CHOP4: chop_nxt = 1'b1;
      `BMWB_BL_PERCMD: chop_nxt = ~i_column_addr_bit_twelve;
      default: chop_nxt = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read latency pipe: each stage holds {valid, chop, start column}
  // Length is fixed at the command edge, so a later word cannot alter it
  reg [4:0] pipe_r [0:`BMWB_PIPE_DEPTH-1];
  wire [4:0] tap;
  wire [3:0] tap_idx;
  integer i;

  // Engine loads one edge after the tap and outputs register one more
  assign tap_idx = o_read_column_latency - 4'h2;
  assign tap = pipe_r[tap_idx];

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (i = 0; i < `BMWB_PIPE_DEPTH; i = i + 1) begin
        pipe_r[i] <= 5'h00;
      end
    end else begin
      pipe_r[0] <= {i_rd_cmd, chop_nxt, i_col_addr};
      for (i = 1; i < `BMWB_PIPE_DEPTH; i = i + 1) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Beat engine, one beat per clock, always eight slots long
  // Chop bursts still run all eight slots, so both lengths end alike
  reg act_r;
  reg [2:0] beat_r;
  reg [2:0] start_r;
  reg chop_r;
  reg write_r;
  reg il_r;
  wire [2:0] col;
  wire beat_used;
  wire rd_slot;

  bmwb_beat_order u_order (
    .i_start_col(start_r),
    .i_beat(beat_r),
    .i_interleave(il_r),
    .i_chop(chop_r),
    .i_write(write_r),
    .o_col(col)
  );

  assign beat_used = ~chop_r | ~beat_r[2];
  assign rd_slot = act_r & ~write_r & beat_used;

  // A read reaching its latency wins over a write in the same cycle
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      act_r <= 1'b0;
      beat_r <= 3'h0;
      start_r <= 3'h0;
      chop_r <= 1'b0;
      write_r <= 1'b0;
      il_r <= 1'b0;
    end else if (tap[4]) begin
      act_r <= 1'b1;
      beat_r <= 3'h0;
      start_r <= tap[2:0];
      chop_r <= tap[3];
      write_r <= 1'b0;
      il_r <= mode_r[`BMWB_BT_BIT];
    end else if (i_wr_cmd) begin
      act_r <= 1'b1;
      beat_r <= 3'h0;
      start_r <= i_col_addr;
      chop_r <= chop_nxt;
      write_r <= 1'b1;
      il_r <= mode_r[`BMWB_BT_BIT];
    end else if (act_r) begin
      beat_r <= beat_r + 3'h1;
      if (beat_r == 3'h7) begin
        act_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Beat outputs, one register stage after the engine
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_beat_col <= 3'h0;
      o_rd_beat_valid <= 1'b0;
      o_dq_oe <= 1'b0;
      o_wr_beat_valid <= 1'b0;
      o_burst_eight <= 1'b0;
    end else begin
      o_beat_col <= col;
      o_rd_beat_valid <= rd_slot;
      // Drivers go quiet in the unused chop slots
      o_dq_oe <= rd_slot;
      o_wr_beat_valid <= act_r & write_r & beat_used;
      o_burst_eight <= act_r & ~chop_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loop reset and lock timing
  // Lock is reported, not enforced; holding reads off is the controller's part
  reg [9:0] lock_cnt_r;

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dll_reset <= 1'b0;
      lock_cnt_r <= 10'h000;
      o_loop_locked <= 1'b0;
    end else begin
      o_dll_reset <= mode_r[`BMWB_DLLRST_BIT];
      if (mode_r[`BMWB_DLLRST_BIT]) begin
        lock_cnt_r <= `BMWB_LOCK_CYCLES;
        o_loop_locked <= 1'b0;
      end else if (lock_cnt_r != 10'h000) begin
        lock_cnt_r <= lock_cnt_r - 10'h001;
        o_loop_locked <= (lock_cnt_r == 10'h001);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Idle bank sleep: loop stop and exit timing
  reg sleep_d_r;
  reg [4:0] exit_cnt_r;
  reg [4:0] exit_len_nxt;
  wire sleep_exit;
  wire [31:0] fast_exit_full;
  wire [31:0] slow_exit_full;

  assign sleep_exit = sleep_d_r & ~i_idle_bank_sleep;
  // Exit counts are a few cycles, so five bits hold them
  assign fast_exit_full = `BMWB_FAST_EXIT_CYC;
  assign slow_exit_full = `BMWB_SLOW_EXIT_CYC;

  // Bit 12 picks the exit length here when sleep ends; it never matters while awake
  always @* begin
    exit_len_nxt = slow_exit_full[4:0];
    if (mode_r[`BMWB_PPD_BIT]) begin
      exit_len_nxt = fast_exit_full[4:0];
    end
  end

  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_d_r <= 1'b0;
      exit_cnt_r <= 5'h00;
      o_dll_stopped <= 1'b0;
      o_sleep_exit_busy <= 1'b0;
    end else begin
      sleep_d_r <= i_idle_bank_sleep;
      // Bit only consulted while asleep
      o_dll_stopped <= i_idle_bank_sleep & ~mode_r[`BMWB_PPD_BIT];
      if (sleep_exit) begin
        exit_cnt_r <= exit_len_nxt;
        o_sleep_exit_busy <= 1'b1;
      end else if (exit_cnt_r != 5'h00) begin
        exit_cnt_r <= exit_cnt_r - 5'h01;
        o_sleep_exit_busy <= (exit_cnt_r != 5'h01);
      end else begin
        o_sleep_exit_busy <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered copies of the word and its decoded timings
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_base_mode_word <= `BMWB_WORD_RESET;
      o_read_column_latency <= `BMWB_CL_MIN;
      o_write_recovery <= `BMWB_WR_MIN;
    end else begin
      o_base_mode_word <= mode_r;
      o_read_column_latency <= cl_nxt;
      o_write_recovery <= wr_nxt;
    end
  end

endmodule

// *** bmwb_asserts.sv ***
// Checker on the mode word and burst ports.
// Bound into the burst block; one clock, async low reset.
`timescale 1ns/1ps
module bmwb_asserts (
  input wire i_mclk,
  input wire i_reset_n,
  input wire i_mode_set_command,
  input wire [18:0] i_mode_word,
  input wire i_rd_cmd,
  input wire i_idle_bank_sleep,
  input wire [18:0] o_base_mode_word,
  input wire o_rd_beat_valid,
  input wire o_dq_oe,
  input wire o_burst_eight,
  input wire o_dll_reset,
  input wire [3:0] o_read_column_latency,
  input wire [3:0] o_write_recovery,
  input wire o_dll_stopped
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  sequence s_on4;
    o_rd_beat_valid [*4];
  endsequence
  sequence s_off4;
    !o_rd_beat_valid [*4];
  endsequence
  a_dll_start: assert property (i_mode_set_command && i_mode_word[8] |-> ##[1:3] o_dll_reset)
    else $error("loop reset pulse missing");
  a_dll_clear: assert property (o_dll_reset |=> !o_dll_reset && !o_base_mode_word[8])
    else $error("loop reset bit stuck");
  a_oe_match: assert property (o_dq_oe == o_rd_beat_valid)
    else $error("driver enable differs from beats");
  a_lat_five: assert property (i_rd_cmd && o_read_column_latency == 4'h5 |-> ##5 !o_rd_beat_valid ##1 o_rd_beat_valid)
    else $error("first beat off latency five");
  a_lat_max: assert property (i_rd_cmd && o_read_column_latency == 4'hD |-> ##13 !o_rd_beat_valid ##1 o_rd_beat_valid)
    else $error("first beat off latency thirteen");
  a_lat_range: assert property (o_read_column_latency inside {[4'h5:4'hD]})
    else $error("latency out of range");
  a_rec_codes: assert property (o_write_recovery inside {4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE})
    else $error("recovery not a legal count");
  // Chop tail must stay released so another device can drive the bus
  a_chop_tail: assert property ($rose(o_rd_beat_valid) && !o_burst_eight |-> s_on4 ##1 s_off4)
    else $error("chop read shape wrong");
  a_eight_run: assert property ($rose(o_rd_beat_valid) && o_burst_eight |-> o_rd_beat_valid [*8])
    else $error("eight beat read broken");
  a_stop_sleep: assert property (o_dll_stopped |-> $past(i_idle_bank_sleep))
    else $error("loop stopped outside sleep");
endmodule

// *** bmwb_ctrl_model.sv ***
// Memory controller model: mode sets, commands, sleep level.
// Drives at rising edges; the bench calls its tasks.
`timescale 1ns/1ps
module bmwb_ctrl_model (
  input wire i_mclk,
  output reg o_ms,
  output reg [18:0] o_word,
  output reg o_rd,
  output reg o_wr,
  output reg [2:0] o_col,
  output reg o_a12,
  output reg o_slp
);
  initial begin
    {o_ms, o_word, o_rd, o_wr, o_col, o_a12, o_slp} = 25'h0;
  end
  // Called only between bursts, never mid transfer
  task mode(input [18:0] w);
    @(posedge i_mclk);
    o_ms <= 1'b1;
    o_word <= w & 19'h31F7F;
    @(posedge i_mclk);
    o_ms <= 1'b0;
    o_word <= ~o_word;
  endtask
  // Unsampled lines show the inverse so stale values cannot pass
  task cmd(input r, input [2:0] s, input a);
    @(posedge i_mclk);
    o_rd <= r;
    o_wr <= ~r;
    o_col <= s;
    o_a12 <= a;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_col <= ~s;
    o_a12 <= ~a;
  endtask
  // Recovery code for a recovery time in ns at the 100 ns clock, rounded up
  function [2:0] wr_code(input integer ns);
    integer cyc;
    begin
      cyc = (ns + 99) / 100;
      case (cyc)
        0, 1, 2, 3, 4, 5: wr_code = 3'h1;
        6: wr_code = 3'h2;
        7: wr_code = 3'h3;
        8: wr_code = 3'h4;
        9, 10: wr_code = 3'h5;
        11, 12: wr_code = 3'h6;
        default: wr_code = 3'h7;
      endcase
    end
  endfunction
  task sleep(input v);
    @(posedge i_mclk);
    o_slp <= v;
  endtask
endmodule

// *** bmwb_mode_burst_bench.sv ***
// Self-checking bench for the mode word and burst block.
// Controller model drives inputs; checker bound below.
`timescale 1ns/1ps
module bmwb_mode_burst_bench;
  reg clk;
  reg rst_n;
  wire ms, rd, wr, a12, slp, rv, oe, wv, b8, dr, lk, ds, eb;
  wire [18:0] mw, bw;
  wire [2:0] col, bc;
  wire [3:0] cl, wrc;
  integer compares, miscompares, k;
  bmwb_ctrl_model ctl (.i_mclk(clk), .o_ms(ms), .o_word(mw), .o_rd(rd), .o_wr(wr),
    .o_col(col), .o_a12(a12), .o_slp(slp));
  bmwb_mode_burst dut (.i_mclk(clk), .i_reset_n(rst_n), .i_mode_set_command(ms),
    .i_mode_word(mw), .i_rd_cmd(rd), .i_wr_cmd(wr), .i_col_addr(col),
    .i_column_addr_bit_twelve(a12), .i_idle_bank_sleep(slp), .o_base_mode_word(bw),
    .o_beat_col(bc), .o_rd_beat_valid(rv), .o_dq_oe(oe), .o_wr_beat_valid(wv),
    .o_burst_eight(b8), .o_dll_reset(dr), .o_loop_locked(lk), .o_read_column_latency(cl),
    .o_write_recovery(wrc), .o_dll_stopped(ds), .o_sleep_exit_busy(eb));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  function [2:0] col_exp(input r, input [2:0] s, input [2:0] k, input bt, input ch);
    if (!r) col_exp = ch ? {s[2], k[1:0]} : k;
    else if (bt) col_exp = s ^ k;
    else col_exp = {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction
  // Shared burst: program word, issue one command, judge eight slots
  task burst(input [18:0] w, input r, input [2:0] s, input a, input ch, input [3:0] m);
    ctl.mode(w);
    settle;
    chk(bw, w);
    chk(cl, m);
    ctl.cmd(r, s, a);
    if (r) repeat (m) @(posedge clk);
    #1;
    for (k = 0; !r && wv !== 1'b1 && k < 4; k++) begin
      @(posedge clk);
      #1;
    end
    for (k = 0; k < 8; k++) begin
      chk(r ? rv : wv, !ch || !k[2]);
      chk(oe, r && (!ch || !k[2]));
      if (!ch || !k[2]) begin
        chk(bc, col_exp(r, s, k[2:0], w[3], ch));
      end
      chk(b8, !ch);
      @(posedge clk);
      #1;
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    repeat (12) @(posedge clk);
    #1;
    chk({bw, lk, cl, wrc}, {20'h0, 4'h5, 4'h5});
    @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task t_dll;
    ctl.mode(19'h00110);
    #1;
    for (k = 0; dr !== 1'b1 && k < 4; k++) begin
      @(posedge clk);
      #1;
    end
    chk({dr, bw[8]}, 2'h3);
    @(posedge clk);
    #1;
    chk({dr, bw[8]}, 2'h0);
    repeat (500) @(posedge clk);
    #1;
    chk(lk, 0);
    repeat (20) @(posedge clk);
    #1;
    chk(lk, 1);
  endtask
  task t_decode;
    reg [2:0] w;
    for (k = 0; k < 8; k++) begin
      w = k[2:0];
      ctl.mode({7'h00, w, 2'h0, w, 4'h0});
      settle;
      chk(wrc, 32'hECA87655 >> {w, 2'b00} & 4'hF);
      chk(cl, (w == 3'h0) ? 4'h5 : {1'b0, w} + 4'h4);
    end
    ctl.mode({7'h00, ctl.wr_code(650), 9'h010});
    settle;
    chk(wrc, 4'h7);
  endtask
  task t_reads;
    burst(19'h00010, 1, 3'h1, 0, 0, 4'h5);
    burst(19'h00018, 1, 3'h7, 0, 0, 4'h5);
    burst(19'h0001A, 1, 3'h5, 0, 1, 4'h5);
    burst(19'h00012, 1, 3'h6, 0, 1, 4'h5);
    burst(19'h00013, 1, 3'h4, 0, 0, 4'h5);
  endtask
  task t_percmd;
    burst(19'h00011, 1, 3'h3, 0, 1, 4'h5);
    burst(19'h00011, 1, 3'h3, 1, 0, 4'h5);
    burst(19'h00011, 0, 3'h5, 0, 1, 4'h5);
  endtask
  task t_writes;
    burst(19'h00012, 0, 3'h5, 0, 1, 4'h5);
    burst(19'h00010, 0, 3'h3, 1, 0, 4'h5);
  endtask
  task t_latency;
    burst(19'h00014, 1, 3'h2, 0, 0, 4'hD);
    ctl.mode(19'h00004);
    settle;
    chk(cl, 4'hC);
  endtask
  task t_sleep(input p, input [3:0] n);
    reg [3:0] cnt;
    ctl.mode({6'h00, p, 12'h010});
    settle;
    chk(ds, 0);
    ctl.sleep(1);
    settle;
    chk(ds, !p);
    ctl.sleep(0);
    cnt = 4'h0;
    repeat (8) begin
      @(posedge clk);
      #1;
      cnt = cnt + {3'h0, eb};
    end
    chk(cnt, n);
  endtask
  ////////////////////////////////////////
  initial begin
    compares = 0;
    miscompares = 0;
    rst_n = 1'b0;
    t_reset;
    t_dll;
    t_decode;
    t_reads;
    t_percmd;
    t_writes;
    t_latency;
    t_sleep(0, 4'h3);
    t_sleep(1, 4'h1);
    wrap_up;
  end
  // Run needs about 840 cycles; allow about six times that
  initial begin
    #500000;
    miscompares++;
    wrap_up;
  end
endmodule
bind bmwb_mode_burst bmwb_asserts u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_mode_set_command(i_mode_set_command), .i_mode_word(i_mode_word), .i_rd_cmd(i_rd_cmd),
  .i_idle_bank_sleep(i_idle_bank_sleep), .o_base_mode_word(o_base_mode_word),
  .o_rd_beat_valid(o_rd_beat_valid), .o_dq_oe(o_dq_oe), .o_burst_eight(o_burst_eight),
  .o_dll_reset(o_dll_reset), .o_read_column_latency(o_read_column_latency),
  .o_write_recovery(o_write_recovery), .o_dll_stopped(o_dll_stopped));
